// file: design/ecr_pkg.sv
// Package for the event channel router: register map, field layout, encodings.
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
package ecr_pkg;
  localparam int ECR_AW = 5;
  localparam logic [ECR_AW-1:0] ECR_OFF_CTRL   = 5'h00;
  localparam logic [ECR_AW-1:0] ECR_OFF_CHAN   = 5'h04;
  localparam logic [ECR_AW-1:0] ECR_OFF_USER   = 5'h08;
  localparam logic [ECR_AW-1:0] ECR_OFF_STATE  = 5'h0C;
  localparam logic [ECR_AW-1:0] ECR_OFF_IENCLR = 5'h10;
  localparam logic [ECR_AW-1:0] ECR_OFF_IENSET = 5'h14;
  localparam logic [ECR_AW-1:0] ECR_OFF_IFLAG  = 5'h18;
  // Control fields
  localparam int ECR_CTRL_RST_BIT  = 0;
  localparam int ECR_CTRL_KEEP_BIT = 4;
  // Channel config fields
  localparam int ECR_CH_SEL_LSB  = 0;
  localparam int ECR_CH_TRIG_BIT = 8;
  localparam int ECR_CH_GEN_LSB  = 16;
  localparam int ECR_CH_PATH_LSB = 24;
  localparam int ECR_CH_EDGE_LSB = 26;
  // Status / interrupt halves
  localparam int ECR_LO_LSB = 0;
  localparam int ECR_HI_LSB = 8;
  // User mux fields
  localparam int ECR_USR_SEL_LSB = 0;
  localparam int ECR_USR_CH_LSB  = 8;
  localparam logic [31:0] ECR_ZERO32 = 32'h0000_0000;
  localparam logic [7:0]  ECR_GEN_NONE = 8'h00;

  typedef enum logic [1:0] {
    ECR_EDGE_NONE = 2'h0,
    ECR_EDGE_RISE = 2'h1,
    ECR_EDGE_FALL = 2'h2,
    ECR_EDGE_BOTH = 2'h3
  } ecr_edge_t;

  typedef enum logic [1:0] {
    ECR_PATH_SYNC  = 2'h0,
    ECR_PATH_RESYN = 2'h1,
    ECR_PATH_ASYNC = 2'h2,
    ECR_PATH_RSVD  = 2'h3
  } ecr_path_t;

  // Per-channel configuration record
  typedef struct packed {
    ecr_edge_t  edge_select;
    ecr_path_t  path;
    logic [7:0] generator_select;
  } ecr_chcfg_t;
endpackage

// file: design/ecr_router.sv
// Event channel router: per-channel generator pick, edge detect, status, irqs.
// Assumes generators and users come from other clock domains (synchronised
// here), and an Avalon-MM master that honours waitrequest.
// Operation
// - Clocked path detects rising, falling or both edges per edge field.
// - Any channel selects any generator; reset value zero means none.
// - Pending bit set while an event is not yet taken by all users.
// - Users-ready bit set when every attached user can accept an event.
// - Status bits update only on synchronous or resynchronized paths.
// - Soft trigger with channel number makes one event on that channel if it is on a synchronous or resynchronized path.
// - Each channel has overrun and detect flags in the flag register.
// - Enable-set ones enable, enable-clear ones disable, zeros ignored.
// - Interrupt asserted while flag and enable set, until either clears.
// - All enabled conditions OR into one interrupt request output.
// - Overrun when event arrives while user unready or previous still pending.
// - Overrun flag only on resynchronized path; zero on asynchronous.
// - Detect flag set on detected event, resynchronized path only.
// - Interrupt output usable as an asynchronous wake-up source.
// - In sleep an event restarts only its channel clock, then stops it.
// - Asynchronous channels forward events with no channel clock activity.
// - Soft reset restores all registers and abandons events in flight.
// - Edge field: 0 none, 1 rising, 2 falling, 3 both.
// - Path field: 0 synchronous, 1 resynchronized, 2 asynchronous, 3 reserved.
// - Keep-alive 0 requests clock per event; 1 keeps it running.
`timescale 1ns/1ps
`default_nettype none
module ecr_router
  import ecr_pkg::*;
#(
  parameter int NCH  = 8,
  parameter int NGEN = 256,
  parameter int NUSR = 16
) (
  input  wire  logic              clk,
  input  wire  logic              reset,
  input  wire  logic [ECR_AW-1:0] avs_address,
  input  wire  logic              avs_read,
  input  wire  logic              avs_write,
  input  wire  logic [31:0]       avs_writedata,
  input  wire  logic [3:0]        avs_byteenable,
  output var   logic [31:0]       avs_readdata,
  output var   logic              avs_waitrequest,
  input  wire  logic [NGEN-1:0]   gen_events,
  input  wire  logic [NUSR-1:0]   user_ready,
  input  wire  logic [NUSR-1:0]   user_taken,
  output var   logic [NCH-1:0]    chan_events,
  output var   logic [NCH-1:0]    channel_gen_clock,
  output var   logic [NUSR*8-1:0] user_channel_sel,
  output var   logic              irq
);
  localparam int CW = $clog2(NCH);

  // Register state
  logic             keepalive_r;
  ecr_chcfg_t       cfg_r [NCH];
  logic [7:0]       ch_ptr_r;
  logic [7:0]       usr_ptr_r;
  logic [7:0]       usr_map_r [NUSR];
  logic [NCH-1:0]   ien_ovr_r, ien_det_r;
  logic [NCH-1:0]   flg_ovr_r, flg_det_r;
  logic [NCH-1:0]   pend_r, rdy_r;
  logic [NCH-1:0]   prev_r, evt_r, soft_r;
  logic             ack_r;
  logic             soft_rst;

  // Two-stage synchronisers for generator and user inputs
  logic [NGEN-1:0] gen_s1_r, gen_s2_r;
  logic [NUSR-1:0] rdy_s1_r, rdy_s2_r, tak_s1_r, tak_s2_r;
  always_ff @(posedge clk) begin
    gen_s1_r <= gen_events;
    gen_s2_r <= gen_s1_r;
    rdy_s1_r <= user_ready;
    rdy_s2_r <= rdy_s1_r;
    tak_s1_r <= user_taken;
    tak_s2_r <= tak_s1_r;
  end

  // Bus access decode; one wait cycle then ack
  logic wr_go, rd_go;
  assign wr_go = avs_write && ack_r;
  assign rd_go = avs_read && ack_r;
  assign soft_rst = wr_go && avs_address == ECR_OFF_CTRL && avs_byteenable[0]
                    && avs_writedata[ECR_CTRL_RST_BIT];
  // Ack alternates so each request gets exactly one answer cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end
  // Waitrequest idles high, so a master never takes a stale answer
  always_ff @(posedge clk) begin
    avs_waitrequest <= reset ? 1'b1 : !((avs_read || avs_write) && !ack_r);
  end

  // Channel pointer, config and soft trigger; a soft reset discards the rest
  logic [CW-1:0] wsel;
  assign wsel = avs_writedata[ECR_CH_SEL_LSB +: CW];
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      keepalive_r <= 1'b0;
      ch_ptr_r    <= 8'h00;
      soft_r      <= '0;
      for (int i = 0; i < NCH; i++) begin
        cfg_r[i] <= '{ECR_EDGE_NONE, ECR_PATH_SYNC, ECR_GEN_NONE};
      end
    end else begin
      soft_r <= '0;
      if (wr_go && avs_address == ECR_OFF_CTRL && avs_byteenable[0]) begin
        keepalive_r <= avs_writedata[ECR_CTRL_KEEP_BIT];
      end
      if (wr_go && avs_address == ECR_OFF_CHAN) begin
        if (avs_byteenable[0]) begin
          ch_ptr_r <= avs_writedata[ECR_CH_SEL_LSB +: 8];
        end
        // Whole-word write commits config; narrow write only moves the pointer
        if (avs_byteenable == 4'hF && 32'(avs_writedata[ECR_CH_SEL_LSB +: 8]) < NCH) begin
          cfg_r[wsel] <= '{ecr_edge_t'(avs_writedata[ECR_CH_EDGE_LSB +: 2]),
                           ecr_path_t'(avs_writedata[ECR_CH_PATH_LSB +: 2]),
                           avs_writedata[ECR_CH_GEN_LSB +: 8]};
          soft_r[wsel] <= avs_writedata[ECR_CH_TRIG_BIT];
        end
      end
    end
  end

  // User multiplexer table
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      usr_ptr_r <= 8'h00;
      for (int u = 0; u < NUSR; u++) begin
        usr_map_r[u] <= 8'h00;
      end
    end else if (wr_go && avs_address == ECR_OFF_USER) begin
      if (avs_byteenable[0]) begin
        usr_ptr_r <= avs_writedata[ECR_USR_SEL_LSB +: 8];
      end
      if (avs_byteenable[1:0] == 2'h3 && 32'(avs_writedata[ECR_USR_SEL_LSB +: 8]) < NUSR) begin
        usr_map_r[avs_writedata[ECR_USR_SEL_LSB +: $clog2(NUSR)]] <=
          avs_writedata[ECR_USR_CH_LSB +: 8];
      end
    end
  end

  // Per-channel source, edge detector and user bookkeeping
  logic [NCH-1:0] src, det, clocked, resyn, allrdy, anypend, async_ev;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      src[c]     = gen_s2_r[cfg_r[c].generator_select] &&
                   cfg_r[c].generator_select != ECR_GEN_NONE;
      clocked[c] = cfg_r[c].path == ECR_PATH_SYNC || cfg_r[c].path == ECR_PATH_RESYN;
      resyn[c]   = cfg_r[c].path == ECR_PATH_RESYN;
      unique case (cfg_r[c].edge_select)
        ECR_EDGE_NONE: det[c] = 1'b0;
        ECR_EDGE_RISE: det[c] = src[c] && !prev_r[c];
        ECR_EDGE_FALL: det[c] = !src[c] && prev_r[c];
        ECR_EDGE_BOTH: det[c] = src[c] != prev_r[c];
      endcase
      // Soft trigger bypasses the edge field; keep-alive is left to software
      det[c]      = clocked[c] && (det[c] || soft_r[c]);
      async_ev[c] = cfg_r[c].path == ECR_PATH_ASYNC && src[c];
      allrdy[c]   = 1'b1;
      for (int u = 0; u < NUSR; u++) begin
        if (32'(usr_map_r[u]) == c + 1) begin
          allrdy[c] = allrdy[c] && rdy_s2_r[u];
        end
      end
    end
  end

  // Pending tracking: per channel, set of users still owing the event
  logic [NUSR-1:0] owe_r;
  logic [NUSR-1:0] owe_nxt;
  always_comb begin
    owe_nxt = owe_r & ~tak_s2_r;
    for (int u = 0; u < NUSR; u++) begin
      for (int c = 0; c < NCH; c++) begin
        if (32'(usr_map_r[u]) == c + 1 && det[c]) begin
          owe_nxt[u] = 1'b1; // Set wins over take
        end
      end
    end
  end
  // A channel is busy while any of its users still owes the event
  always_comb begin
    anypend = '0;
    for (int c = 0; c < NCH; c++) begin
      for (int u = 0; u < NUSR; u++) begin
        if (32'(usr_map_r[u]) == c + 1 && owe_r[u]) begin
          anypend[c] = 1'b1;
        end
      end
    end
  end

  // Channel state; status stays zero off the clocked paths
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      prev_r <= '0;
      evt_r  <= '0;
      owe_r  <= '0;
      pend_r <= '0;
      rdy_r  <= '0;
    end else begin
      prev_r <= src;
      evt_r  <= det;
      owe_r  <= owe_nxt;
      for (int c = 0; c < NCH; c++) begin
        pend_r[c] <= clocked[c] && anypend[c];
        rdy_r[c]  <= clocked[c] && allrdy[c];
      end
    end
  end

  // Event outputs: clocked channels pulse, async channels follow the source
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      chan_events <= '0;
    end else begin
      chan_events <= det | async_ev;
    end
  end

  // Channel clock request, clocked paths only: always on with keep-alive, else while busy
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      channel_gen_clock <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        channel_gen_clock[c] <= clocked[c] &&
          (keepalive_r || det[c] || evt_r[c] || anypend[c]);
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      ien_ovr_r <= '0;
      ien_det_r <= '0;
    end else if (wr_go && avs_address == ECR_OFF_IENSET) begin
      if (avs_byteenable[0]) ien_ovr_r <= ien_ovr_r | avs_writedata[ECR_LO_LSB +: NCH];
      if (avs_byteenable[1]) ien_det_r <= ien_det_r | avs_writedata[ECR_HI_LSB +: NCH];
    end else if (wr_go && avs_address == ECR_OFF_IENCLR) begin
      if (avs_byteenable[0]) ien_ovr_r <= ien_ovr_r & ~avs_writedata[ECR_LO_LSB +: NCH];
      if (avs_byteenable[1]) ien_det_r <= ien_det_r & ~avs_writedata[ECR_HI_LSB +: NCH];
    end
  end

  // Flags: hardware set wins over write-one-to-clear in the same cycle
  logic [NCH-1:0] clr_ovr, clr_det, set_ovr, set_det;
  always_comb begin
    clr_ovr = '0;
    clr_det = '0;
    if (wr_go && avs_address == ECR_OFF_IFLAG) begin
      if (avs_byteenable[0]) clr_ovr = avs_writedata[ECR_LO_LSB +: NCH];
      if (avs_byteenable[1]) clr_det = avs_writedata[ECR_HI_LSB +: NCH];
    end
    // Overrun: new event while a user is unready or still owes the last one
    set_ovr = det & resyn & (~allrdy | anypend);
    set_det = det & resyn;
  end
  // Flags; a soft reset clears every overrun and detect flag
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      flg_ovr_r <= '0;
      flg_det_r <= '0;
    end else begin
      flg_ovr_r <= (flg_ovr_r & ~clr_ovr) | set_ovr;
      flg_det_r <= (flg_det_r & ~clr_det) | set_det;
    end
  end

  // Combined interrupt; a level, so it can wake from sleep without a clock
  always_ff @(posedge clk) begin
    if (reset || soft_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((flg_ovr_r & ien_ovr_r) | (flg_det_r & ien_det_r));
    end
  end

  // Read mux; unmapped offsets read zero
  logic [31:0] rdata;
  logic [CW-1:0] rsel;
  assign rsel = ch_ptr_r[CW-1:0];
  always_comb begin
    rdata = ECR_ZERO32;
    unique case (avs_address)
      ECR_OFF_CTRL: rdata[ECR_CTRL_KEEP_BIT] = keepalive_r;
      ECR_OFF_CHAN: begin
        rdata[ECR_CH_SEL_LSB +: 8] = ch_ptr_r;
        if (32'(ch_ptr_r) < NCH) begin
          rdata[ECR_CH_GEN_LSB +: 8]  = cfg_r[rsel].generator_select;
          rdata[ECR_CH_PATH_LSB +: 2] = cfg_r[rsel].path;
          rdata[ECR_CH_EDGE_LSB +: 2] = cfg_r[rsel].edge_select;
        end
      end
      ECR_OFF_USER: begin
        rdata[ECR_USR_SEL_LSB +: 8] = usr_ptr_r;
        if (32'(usr_ptr_r) < NUSR) begin
          rdata[ECR_USR_CH_LSB +: 8] = usr_map_r[usr_ptr_r[$clog2(NUSR)-1:0]];
        end
      end
      ECR_OFF_STATE: begin
        rdata[ECR_LO_LSB +: NCH] = rdy_r;
        rdata[ECR_HI_LSB +: NCH] = pend_r;
      end
      ECR_OFF_IENCLR, ECR_OFF_IENSET: begin
        rdata[ECR_LO_LSB +: NCH] = ien_ovr_r;
        rdata[ECR_HI_LSB +: NCH] = ien_det_r;
      end
      ECR_OFF_IFLAG: begin
        rdata[ECR_LO_LSB +: NCH] = flg_ovr_r;
        rdata[ECR_HI_LSB +: NCH] = flg_det_r;
      end
      default: rdata = ECR_ZERO32;
    endcase
  end
  // Read data captured in the wait cycle, held until the next access
  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= ECR_ZERO32;
    end else if ((avs_read || avs_write) && !ack_r) begin
      avs_readdata <= avs_read ? rdata : ECR_ZERO32;
    end
  end

  // User multiplexer settings for the consumers
  always_ff @(posedge clk) begin
    for (int u = 0; u < NUSR; u++) begin
      user_channel_sel[u*8 +: 8] <= (reset || soft_rst) ? 8'h00 : usr_map_r[u];
    end
  end
endmodule
`default_nettype wire

// file: tb/ecr_router_props.sv
// Checker for the event channel router: bus handshake, irq and reset relations.
// Assumes it is bound to ecr_router and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ecr_router_props
  import ecr_pkg::*;
#(
  parameter int NCH  = 8,
  parameter int NUSR = 16
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ECR_AW-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [NCH-1:0]    chan_events,
  input wire logic [NUSR*8-1:0] user_channel_sel,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [2:0] act_r;
  // Short window after an event or a write; an irq rising outside it has no cause
  always_ff @(posedge clk) begin
    if (reset) act_r <= 3'h0;
    else if ((chan_events != '0) || avs_write) act_r <= 3'h6;
    else if (act_r != 3'h0) act_r <= act_r - 3'h1;
  end
  chk_wait_one:
    assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait low too long");
  chk_wait_cause:
    assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  chk_ack_bound:
    assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered");
  chk_rd_unmapped:
    assert property (avs_read && !avs_waitrequest && avs_address > 5'h18 |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  chk_irq_hold:
    assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("irq dropped without a write");
  chk_irq_cause:
    assert property ($rose(irq) |-> act_r != 3'h0) else $error("irq rose without cause");
  chk_sel_write:
    assert property (!$stable(user_channel_sel) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("user routing changed without a write");
  chk_reset_quiet:
    assert property ($fell(reset) |-> !irq && chan_events == '0 && user_channel_sel == '0)
    else $error("outputs not cleared by reset");
  cov_irq: cover property ($rose(irq));
  cov_event: cover property ($rose(chan_events[0]));
  cov_unmapped: cover property (avs_read && !avs_waitrequest && avs_address > 5'h18);
endmodule
bind ecr_router ecr_router_props #(.NCH(NCH), .NUSR(NUSR)) u_props (.clk(clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .chan_events(chan_events), .user_channel_sel(user_channel_sel), .irq(irq));
`default_nettype wire

// file: tb/ecr_peer.sv
// Far-side model: one generator line and users that take routed events.
// Assumes each user listens to the channel named in its select byte.
`timescale 1ns/1ps
`default_nettype none
module ecr_peer #(
  parameter int NGEN = 256,
  parameter int NUSR = 16
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              gen_lvl,
  input  wire logic              stall,
  input  wire logic [7:0]        chan_events,
  input  wire logic [NUSR*8-1:0] user_channel_sel,
  output logic      [NGEN-1:0]   gen_events,
  output logic      [NUSR-1:0]   user_ready,
  output logic      [NUSR-1:0]   user_taken
);
  logic [NUSR-1:0] owe_r;
  // Generator 1 carries the bench level; index 0 means no generator
  assign gen_events = {{(NGEN-2){1'b0}}, gen_lvl, 1'b0};
  // A stalled user neither accepts nor takes, so its event stays owed
  assign user_ready = {NUSR{~stall}};
  assign user_taken = owe_r & {NUSR{~stall}};
  always_ff @(posedge clk) begin
    for (int u = 0; u < NUSR; u++) begin
      if (reset) owe_r[u] <= 1'b0;
      else if (user_channel_sel[u*8 +: 8] inside {[8'h01:8'h08]} &&
               chan_events[3'(user_channel_sel[u*8 +: 8] - 8'h01)]) owe_r[u] <= 1'b1;
      else if (!stall) owe_r[u] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the event channel router over its register bus.
// Assumes ecr_peer stands in for the generators and users.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ecr_pkg::*;
  logic              clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic              gen_lvl = 1'b0, stall = 1'b0, avs_waitrequest, irq;
  logic [ECR_AW-1:0] avs_address = 5'h00;
  logic [31:0]       avs_writedata = 32'h0, q, pulses = 32'h0, avs_readdata, gclk_n = 32'h0;
  logic [3:0]        avs_byteenable = 4'h0;
  logic [255:0]      gen_events;
  logic [15:0]       user_ready, user_taken;
  logic [7:0]        chan_events, channel_gen_clock;
  logic [127:0]      user_channel_sel;
  int                error_cnt = 0, checked = 0;
  // Whole map plus an unmapped word; a channel without users reads ready
  logic [4:0]  adr_tab [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};
  logic [31:0] def_tab [8] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0};
  ecr_router DUT (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gen_events(gen_events),
    .user_ready(user_ready), .user_taken(user_taken), .chan_events(chan_events),
    .channel_gen_clock(channel_gen_clock), .user_channel_sel(user_channel_sel), .irq(irq));
  ecr_peer PEER (.clk(clk), .reset(reset), .gen_lvl(gen_lvl), .stall(stall),
    .chan_events(chan_events), .user_channel_sel(user_channel_sel),
    .gen_events(gen_events), .user_ready(user_ready), .user_taken(user_taken));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // Counted on the falling edge, where registered outputs have settled
  always @(negedge clk) if (chan_events[0] === 1'b1) pulses = pulses + 32'h1;
  always @(negedge clk) if (channel_gen_clock[0] === 1'b1) gclk_n = gclk_n + 32'h1;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      wrap_up();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Slow enough for the two-stage input sync and the flag pipeline
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(adr_tab[i], def_tab[i]);
    wr(ECR_OFF_USER, 32'h0000_0100, 4'h3);
    settle();
    chk("user sel", 32'h1, {24'h0, user_channel_sel[7:0]});
    $display("Test reset and routing done");
    // Each edge code on a resynchronized channel, one rise and one fall
    for (int e = 0; e < 4; e++) begin
      wr(ECR_OFF_CHAN, {4'h0, 2'(e), 2'h1, 8'h01, 16'h0}, 4'hF);
      pulses = 32'h0;
      gclk_n = 32'h0;
      gen_lvl <= 1'b1;
      repeat (8) @(posedge clk);
      gen_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      chk("pulses", (e == 3) ? 32'h2 : (e == 0) ? 32'h0 : 32'h1, pulses);
      chk("clock per event", {31'h0, e != 0}, {31'h0, gclk_n != 32'h0});
    end
    wr(ECR_OFF_CHAN, 32'h0, 4'h1);
    rd(ECR_OFF_CHAN, 32'h0D01_0000);
    rd(ECR_OFF_IFLAG, 32'h0000_0100);
    chk("clock idle", 32'h0, {31'h0, channel_gen_clock[0]});
    $display("Test edge detection done");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ECR_OFF_IENSET, 32'h0000_0100, 4'hF);
    settle();
    chk("irq on", 32'h1, {31'h0, irq});
    wr(ECR_OFF_IENCLR, 32'h0000_0100, 4'hF);
    settle();
    chk("irq off", 32'h0, {31'h0, irq});
    wr(ECR_OFF_IENSET, 32'h0000_0100, 4'hF);
    wr(ECR_OFF_IENCLR, 32'h0, 4'hF);
    settle();
    chk("irq kept", 32'h1, {31'h0, irq});
    wr(ECR_OFF_IFLAG, 32'h0000_0100, 4'hF);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("Test interrupts done");
    wr(ECR_OFF_CTRL, 32'h10, 4'h1);
    settle();
    chk("clock kept", 32'h1, {31'h0, channel_gen_clock[0]});
    @(posedge clk);
    stall <= 1'b1;
    settle();
    pulses = 32'h0;
    wr(ECR_OFF_CHAN, 32'h0501_0100, 4'hF);
    settle();
    chk("soft pulses", 32'h1, pulses);
    rd(ECR_OFF_STATE, 32'h0000_01FE);
    rd(ECR_OFF_IFLAG, 32'h0000_0101);
    stall <= 1'b0;
    settle();
    rd(ECR_OFF_STATE, 32'h0000_00FF);
    $display("Test soft event done");
    // Asynchronous path: level passes straight through, no flags, no clock
    wr(ECR_OFF_IFLAG, 32'h0000_0101, 4'hF);
    wr(ECR_OFF_CTRL, 32'h0, 4'h1);
    wr(ECR_OFF_CHAN, 32'h0201_0000, 4'hF);
    gen_lvl <= 1'b1;
    settle();
    chk("async level", 32'h1, {31'h0, chan_events[0]});
    chk("async clock", 32'h0, {31'h0, channel_gen_clock[0]});
    rd(ECR_OFF_IFLAG, 32'h0);
    gen_lvl <= 1'b0;
    $display("Test async path done");
    wr(ECR_OFF_IENSET, 32'h0000_0101, 4'hF);
    wr(ECR_OFF_CTRL, 32'h11, 4'h1);
    for (int i = 0; i < 8; i++) rd(adr_tab[i], def_tab[i]);
    chk("user sel", 32'h0, {24'h0, user_channel_sel[7:0]});
    $display("Test soft reset done");
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
